// ==== hw/apccc_top.sv ====
// Behaviour
// RULE_01: Ignore bit 6 masks sample-rate error
// RULE_02: Bit clock must be stable 32..256 fs
// RULE_03: Ignore bit 5 masks bit-clock error
// RULE_04: Master-clock ratio check, bit 4 masks
// RULE_05: Master-clock halt check, bit 3 masks
// RULE_06: Clocks held low mean missing, powerdown
// RULE_07: Bit 1 disables automatic divider setting
// RULE_08: Host disables autoset in reference-voltage mode
// RULE_09: Bit 0 masks PLL unlock from error
// RULE_10: PLL status bit always shows true lock
// RULE_11: Format field: I2S, DSP, right, left
// RULE_12: Width field 16/20/24/32, resets 24
// RULE_13: Data offset in bit clocks from frame
// RULE_14: Ignore and autoset bits reset to zero
// RULE_15: Path field: mute, own, opposite channel
// RULE_16: Missing period code 0..7 is 1..8 s
// RULE_17: Autoset ignores manual divider values
// RULE_18: Clock error is OR, mutes path
`timescale 1ns/1ps
`default_nettype none

module apccc_top
    import apccc_pkg::*;
#(
    parameter int MISS_STEP_CYC = apccc_pkg::MISSING_STEP_CYC,
    parameter int FRAME_MIN     = apccc_pkg::FRAME_MIN_CYC,
    parameter int FRAME_MAX     = apccc_pkg::FRAME_MAX_CYC
) (
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rst_b,
    input  wire logic       clk_en,
    // Control port
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    // Audio clock pins
    input  wire logic       mclk_pin,
    input  wire logic       bclk_pin,
    input  wire logic       lrclk_pin,
    input  wire logic       pll_locked,
    // Divider
    input  wire logic [6:0] manual_dac_div,
    output logic            divider_auto,
    output logic      [6:0] dac_div,
    // Audio path configuration
    output logic      [1:0] audio_format_select,
    output logic      [5:0] sample_bits,
    output logic      [7:0] sample_offset,
    output logic      [1:0] left_path_select,
    output logic      [1:0] right_path_select,
    // Supervision
    output logic            clock_error,
    output logic            dac_powerdown
);
    import apccc_pkg::*;

    // ==========================================================
    // State
    typedef struct packed {
        logic [2:0]  mclk_s;
        logic [2:0]  bclk_s;
        logic [2:0]  lrclk_s;
        logic [1:0]  pll_s;
        logic [6:0]  clk_check;
        logic [1:0]  fmt;
        logic [1:0]  len;
        logic [7:0]  data_ofs;
        logic [1:0]  lpath;
        logic [1:0]  rpath;
        logic [2:0]  miss_per;
        logic [15:0] frame_cyc;
        logic [8:0]  bclk_cnt;
        logic [8:0]  bclk_prev;
        logic [11:0] mclk_cnt;
        logic [15:0] halt_cnt;
        logic [31:0] miss_cnt;
        logic        rate_err;
        logic        bclk_err;
        logic        mratio_err;
        logic        halt_err;
        logic        miss_err;
        logic [6:0]  auto_div;
        logic [7:0]  rdata;
        logic        err;
        logic        pdown;
        logic [1:0]  lpath_out;
        logic [1:0]  rpath_out;
        logic [6:0]  div_out;
        logic [5:0]  bits_out;
        logic        auto_out;
    } apccc_state_type;

    apccc_state_type state_reg;
    apccc_state_type state_next;

    // ==========================================================
    // Helpers
    function automatic logic mclk_ratio_ok(input logic [11:0] cnt);
        logic ok;
        ok = 1'b0;
        for (int k = 1; k <= 4; k++) begin
            if ((int'(cnt) >= 128 * k - MCLK_RATIO_TOL) && (int'(cnt) <= 128 * k + MCLK_RATIO_TOL)) begin
                ok = 1'b1;
            end
        end
        return ok;
    endfunction

    function automatic logic [5:0] width_bits(input logic [1:0] code);
        case (code)
            2'h0:    return 6'h10;
            2'h1:    return 6'h14;
            2'h2:    return 6'h18;
            default: return 6'h20;
        endcase
    endfunction

    logic        mclk_rise;
    logic        bclk_rise;
    logic        lr_rise;
    logic [31:0] miss_limit;
    logic        err_any;

    // ==========================================================
    // Next state
    always_comb begin
        state_next = state_reg;
        state_next.mclk_s  = {state_reg.mclk_s[1:0], mclk_pin};
        state_next.bclk_s  = {state_reg.bclk_s[1:0], bclk_pin};
        state_next.lrclk_s = {state_reg.lrclk_s[1:0], lrclk_pin};
        state_next.pll_s   = {state_reg.pll_s[0], pll_locked};
        mclk_rise = state_reg.mclk_s[1] & ~state_reg.mclk_s[2];
        bclk_rise = state_reg.bclk_s[1] & ~state_reg.bclk_s[2];
        lr_rise   = state_reg.lrclk_s[1] & ~state_reg.lrclk_s[2];

        // Register writes
        if (reg_wr) begin
            case (reg_addr)
                ADDR_CLK_CHECK: state_next.clk_check = reg_wdata[6:0];
                ADDR_FMT_LEN: begin
                    state_next.fmt = reg_wdata[FMT_LSB +: 2]; // RULE_11
                    state_next.len = reg_wdata[LEN_LSB +: 2]; // RULE_12
                end
                ADDR_DATA_OFS: state_next.data_ofs = reg_wdata; // RULE_13
                ADDR_PATH_SEL: begin
                    state_next.lpath = reg_wdata[LPATH_LSB +: 2]; // RULE_15
                    state_next.rpath = reg_wdata[RPATH_LSB +: 2]; // RULE_15
                end
                ADDR_MISS_PER: state_next.miss_per = reg_wdata[2:0];
                default: ;
            endcase
        end

        // Register reads
        if (reg_rd) begin
            case (reg_addr)
                ADDR_STATUS: begin
                    state_next.rdata = 8'h00;
                    state_next.rdata[BIT_PLL_STATUS] = state_reg.pll_s[1]; // RULE_10
                    state_next.rdata[BIT_IGN_RATE]   = state_reg.rate_err;
                    state_next.rdata[BIT_IGN_BITCLK] = state_reg.bclk_err;
                    state_next.rdata[BIT_IGN_MHALT]  = state_reg.halt_err;
                    state_next.rdata[BIT_IGN_MISSING] = state_reg.miss_err;
                    state_next.rdata[BIT_AUTO_DIS]   = state_reg.mratio_err;
                    state_next.rdata[BIT_IGN_PLL]    = state_reg.err;
                end
                ADDR_CLK_CHECK: state_next.rdata = {1'b0, state_reg.clk_check};
                ADDR_FMT_LEN:   state_next.rdata = {2'h0, state_reg.fmt, 2'h0, state_reg.len};
                ADDR_DATA_OFS:  state_next.rdata = state_reg.data_ofs;
                ADDR_PATH_SEL:  state_next.rdata = {2'h0, state_reg.lpath, 2'h0, state_reg.rpath};
                ADDR_MISS_PER:  state_next.rdata = {5'h00, state_reg.miss_per};
                default:        state_next.rdata = 8'h00;
            endcase
        end

        // Frame measurement
        if (lr_rise) begin
            state_next.rate_err = (int'(state_reg.frame_cyc) < FRAME_MIN) || (int'(state_reg.frame_cyc) > FRAME_MAX);
            state_next.bclk_err = (int'(state_reg.bclk_cnt) < BCLK_RATIO_MIN)
                || (int'(state_reg.bclk_cnt) > BCLK_RATIO_MAX)
                || (state_reg.bclk_cnt != state_reg.bclk_prev); // RULE_02
            state_next.mratio_err = ~mclk_ratio_ok(state_reg.mclk_cnt); // RULE_04
            state_next.auto_div  = state_reg.mclk_cnt[13-6 +: 5] == 5'h00 ? 7'h00
                                 : 7'(state_reg.mclk_cnt[11:7] - 5'h01);
            state_next.bclk_prev = state_reg.bclk_cnt;
            state_next.frame_cyc = 16'h0000;
            state_next.bclk_cnt  = 9'h000;
            state_next.mclk_cnt  = 12'h000;
        end else begin
            if (state_reg.frame_cyc != 16'hffff) begin
                state_next.frame_cyc = state_reg.frame_cyc + 16'h0001;
            end
            if (int'(state_reg.frame_cyc) > FRAME_MAX) begin
                state_next.rate_err = 1'b1;
            end
            if (bclk_rise && state_reg.bclk_cnt != 9'h1ff) begin
                state_next.bclk_cnt = state_reg.bclk_cnt + 9'h001;
            end
            if (mclk_rise && state_reg.mclk_cnt != 12'hfff) begin
                state_next.mclk_cnt = state_reg.mclk_cnt + 12'h001;
            end
        end

        // Master clock halt
        if (mclk_rise) begin
            state_next.halt_cnt = 16'h0000;
        end else if (int'(state_reg.halt_cnt) < MCLK_HALT_CYC) begin
            state_next.halt_cnt = state_reg.halt_cnt + 16'h0001;
        end
        state_next.halt_err = int'(state_reg.halt_cnt) >= MCLK_HALT_CYC; // RULE_05

        // Clocks missing: both held low, not merely static
        miss_limit = 32'(({29'h0, state_reg.miss_per} + 32'h1) * 32'(MISS_STEP_CYC)); // RULE_16
        if (state_reg.bclk_s[1] || state_reg.lrclk_s[1]) begin
            state_next.miss_cnt = 32'h0; // RULE_06
        end else if (state_reg.miss_cnt < miss_limit) begin
            state_next.miss_cnt = state_reg.miss_cnt + 32'h1;
        end
        state_next.miss_err = state_reg.miss_cnt >= miss_limit;

        // Combined error
        err_any = (state_reg.rate_err   & ~state_reg.clk_check[BIT_IGN_RATE])    // RULE_01
                | (state_reg.bclk_err   & ~state_reg.clk_check[BIT_IGN_BITCLK])  // RULE_03
                | (state_reg.mratio_err & ~state_reg.clk_check[BIT_IGN_MRATIO])  // RULE_04
                | (state_reg.halt_err   & ~state_reg.clk_check[BIT_IGN_MHALT])   // RULE_05
                | (~state_reg.pll_s[1]  & ~state_reg.clk_check[BIT_IGN_PLL]);    // RULE_09
        state_next.err   = err_any; // RULE_18
        state_next.pdown = state_reg.miss_err & ~state_reg.clk_check[BIT_IGN_MISSING]; // RULE_06

        // Outputs
        state_next.lpath_out = err_any ? 2'(APCCC_PATH_MUTE) : state_reg.lpath; // RULE_18
        state_next.rpath_out = err_any ? 2'(APCCC_PATH_MUTE) : state_reg.rpath; // RULE_18
        state_next.div_out   = state_reg.clk_check[BIT_AUTO_DIS] ? manual_dac_div : state_reg.auto_div; // RULE_17
        state_next.bits_out  = width_bits(state_reg.len); // RULE_12
        state_next.auto_out  = ~state_reg.clk_check[BIT_AUTO_DIS]; // RULE_07
    end

    // ==========================================================
    // Registers
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            state_reg           <= '0;
            state_reg.clk_check <= RST_CLK_CHECK; // RULE_14
            state_reg.fmt       <= RST_FMT;
            state_reg.len       <= RST_LEN; // RULE_12
            state_reg.data_ofs  <= RST_DATA_OFS;
            state_reg.lpath     <= RST_PATH;
            state_reg.rpath     <= RST_PATH;
            state_reg.miss_per  <= RST_MISS_PER;
            state_reg.bits_out  <= 6'h18;
            state_reg.auto_out  <= 1'b1; // RULE_14
        end else if (clk_en) begin
            state_reg <= state_next;
        end
    end

    // ==========================================================
    // Output wiring
    assign reg_rdata           = state_reg.rdata;
    assign divider_auto        = state_reg.auto_out; // RULE_07
    assign dac_div             = state_reg.div_out;
    assign audio_format_select = state_reg.fmt;
    assign sample_bits         = state_reg.bits_out;
    assign sample_offset       = state_reg.data_ofs;
    assign left_path_select    = state_reg.lpath_out;
    assign right_path_select   = state_reg.rpath_out;
    assign clock_error         = state_reg.err;
    assign dac_powerdown       = state_reg.pdown;

endmodule // apccc_top

`default_nettype wire

// ==== hw/apccc_pkg.sv ====
package apccc_pkg;

    // ==========================================================
    // Register offsets
    localparam logic [7:0] ADDR_STATUS     = 8'h04;
    localparam logic [7:0] ADDR_CLK_CHECK  = 8'h25;
    localparam logic [7:0] ADDR_FMT_LEN    = 8'h28;
    localparam logic [7:0] ADDR_DATA_OFS   = 8'h29;
    localparam logic [7:0] ADDR_PATH_SEL   = 8'h2a;
    localparam logic [7:0] ADDR_MISS_PER   = 8'h2c;

    // ==========================================================
    // Field positions
    localparam int BIT_IGN_RATE    = 6;
    localparam int BIT_IGN_BITCLK  = 5;
    localparam int BIT_IGN_MRATIO  = 4;
    localparam int BIT_IGN_MHALT   = 3;
    localparam int BIT_IGN_MISSING = 2;
    localparam int BIT_AUTO_DIS    = 1;
    localparam int BIT_IGN_PLL     = 0;
    localparam int BIT_PLL_STATUS  = 4;
    localparam int FMT_LSB         = 4;
    localparam int LEN_LSB         = 0;
    localparam int LPATH_LSB       = 4;
    localparam int RPATH_LSB       = 0;

    // ==========================================================
    // Reset values
    localparam logic [6:0] RST_CLK_CHECK = 7'h00;
    localparam logic [1:0] RST_FMT       = 2'h0;
    localparam logic [1:0] RST_LEN       = 2'h2;
    localparam logic [7:0] RST_DATA_OFS  = 8'h00;
    localparam logic [1:0] RST_PATH      = 2'h1;
    localparam logic [2:0] RST_MISS_PER  = 3'h0;

    // ==========================================================
    // Encodings
    typedef enum logic [1:0] {
        APCCC_PATH_MUTE = 2'h0,
        APCCC_PATH_OWN  = 2'h1,
        APCCC_PATH_CROSS = 2'h2
    } apccc_path_type;

    typedef enum logic [1:0] {
        APCCC_FMT_I2S   = 2'h0,
        APCCC_FMT_DSP   = 2'h1,
        APCCC_FMT_RIGHT_JUSTIFIED = 2'h2,
        APCCC_FMT_LEFT_JUSTIFIED  = 2'h3
    } apccc_format_type;

    // ==========================================================
    // Timing and ratio limits
    localparam int CLK_PERIOD_NS     = 8;
    localparam int BCLK_RATIO_MIN    = 32;
    localparam int BCLK_RATIO_MAX    = 256;
    localparam int MCLK_RATIO_TOL    = 2;
    localparam int MCLK_HALT_NS      = 1000;
    localparam int MCLK_HALT_CYC     = MCLK_HALT_NS / CLK_PERIOD_NS;
    localparam int MISSING_STEP_S    = 1;
    localparam int MISSING_STEP_CYC  = MISSING_STEP_S * 1000000000 / CLK_PERIOD_NS;
    localparam int FRAME_MIN_CYC     = 1302;
    localparam int FRAME_MAX_CYC     = 3907;

endpackage

// ==== hw/dummy_unused_placeholder_removed.sv ====
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ==== verification/apccc_props.sv ====
`timescale 1ns/1ps
`default_nettype none
module apccc_props
    import apccc_pkg::*;
#(
    parameter int MISS_STEP_CYC = apccc_pkg::MISSING_STEP_CYC
) (
    // Clock and control
    input wire logic       clk_sys,
    input wire logic       rst_b,
    input wire logic       clk_en,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    // Pins
    input wire logic       bclk_pin,
    input wire logic       lrclk_pin,
    input wire logic       pll_locked,
    input wire logic [6:0] manual_dac_div,
    // Outputs
    input wire logic       divider_auto,
    input wire logic [6:0] dac_div,
    input wire logic [1:0] audio_format_select,
    input wire logic [5:0] sample_bits,
    input wire logic [7:0] sample_offset,
    input wire logic [1:0] left_path_select,
    input wire logic [1:0] right_path_select,
    input wire logic       clock_error,
    input wire logic       dac_powerdown
);
    logic [5:0] want_bits;
    int         low_cnt;
    assign want_bits = (reg_wdata[1:0] == 2'h3) ? 6'h20 : 6'h10 + 6'h04 * reg_wdata[1:0];
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) low_cnt <= 0;
        else if (bclk_pin || lrclk_pin) low_cnt <= 0;
        else if (low_cnt < MISS_STEP_CYC) low_cnt <= low_cnt + 1;
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    property p_fmt;
        reg_wr && clk_en && reg_addr == ADDR_FMT_LEN |=> audio_format_select == $past(reg_wdata[5:4]);
    endproperty
    a_fmt: assert property (p_fmt) else $error("format output wrong");
    property p_bits;
        reg_wr && clk_en && reg_addr == ADDR_FMT_LEN |-> ##2 sample_bits == $past(want_bits, 2);
    endproperty
    a_bits: assert property (p_bits) else $error("sample width wrong");
    property p_ofs;
        reg_wr && clk_en && reg_addr == ADDR_DATA_OFS |=> sample_offset == $past(reg_wdata);
    endproperty
    a_ofs: assert property (p_ofs) else $error("offset wrong");
    property p_auto;
        reg_wr && clk_en && reg_addr == ADDR_CLK_CHECK |-> ##2 divider_auto == !$past(reg_wdata[1], 2);
    endproperty
    a_auto: assert property (p_auto) else $error("autoset state wrong");
    property p_div;
        (!divider_auto && $stable(manual_dac_div))[*3] |-> dac_div == manual_dac_div;
    endproperty
    a_div: assert property (p_div) else $error("manual divider not used");
    property p_mute;
        clock_error && $past(clock_error) |-> left_path_select == 2'h0 && right_path_select == 2'h0;
    endproperty
    a_mute: assert property (p_mute) else $error("path not muted");
    property p_lock;
        $stable(pll_locked)[*4] ##0 (reg_rd && clk_en && reg_addr == ADDR_STATUS)
            |=> reg_rdata[BIT_PLL_STATUS] == $past(pll_locked);
    endproperty
    a_lock: assert property (p_lock) else $error("lock flag wrong");
    property p_miss;
        $rose(dac_powerdown) |-> low_cnt >= MISS_STEP_CYC;
    endproperty
    a_miss: assert property (p_miss) else $error("powerdown too early");
endmodule // apccc_props
bind apccc_top apccc_props #(.MISS_STEP_CYC(MISS_STEP_CYC)) u_props (
    .clk_sys(clk_sys), .rst_b(rst_b), .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bclk_pin(bclk_pin), .lrclk_pin(lrclk_pin),
    .pll_locked(pll_locked), .manual_dac_div(manual_dac_div), .divider_auto(divider_auto), .dac_div(dac_div),
    .audio_format_select(audio_format_select), .sample_bits(sample_bits), .sample_offset(sample_offset),
    .left_path_select(left_path_select), .right_path_select(right_path_select),
    .clock_error(clock_error), .dac_powerdown(dac_powerdown));
`default_nettype wire

// ==== verification/apccc_source.sv ====
`timescale 1ns/1ps
`default_nettype none
module apccc_source (
    // Control
    input  wire logic       clk_sys,
    input  wire logic       run,
    input  wire logic       mclk_on,
    input  wire logic [7:0] half_bclks,
    // Audio clocks
    output logic            mclk_pin,
    output logic            bclk_pin,
    output logic            lrclk_pin
);
    logic [1:0] ph = 2'h0;
    int         nb = 0;
    initial begin
        mclk_pin = 1'b0;
        bclk_pin = 1'b0;
        lrclk_pin = 1'b0;
    end
    always @(posedge clk_sys) begin
        ph <= ph + 2'h1;
        if (mclk_on && ph[0]) mclk_pin <= ~mclk_pin;
        if (!run) begin
            bclk_pin  <= 1'b0;
            lrclk_pin <= 1'b0;
        end else if (ph == 2'h3) begin
            bclk_pin <= ~bclk_pin;
            if (bclk_pin && nb + 1 >= half_bclks) begin
                lrclk_pin <= ~lrclk_pin;
                nb        <= 0;
            end else if (bclk_pin) begin
                nb <= nb + 1;
            end
        end
    end
endmodule // apccc_source
`default_nettype wire

// ==== verification/audio_port_clock_check_config_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module audio_port_clock_check_config_bench;
    import apccc_pkg::*;
    logic       clk_sys = 0, rst_b = 0, clk_en = 1, reg_wr = 0, reg_rd = 0, pll_locked = 1;
    logic       run = 1, mclk_on = 1, mclk_pin, bclk_pin, lrclk_pin, divider_auto, ce, pd;
    logic [7:0] reg_addr = 0, reg_wdata = 0, half = 32, reg_rdata, ofs, d;
    logic [6:0] manual_dac_div = 0, dac_div;
    logic [1:0] fmt, lp, rp;
    logic [5:0] bits;
    logic [7:0] mdl [logic [7:0]];
    logic [7:0] addrs [6] = '{8'h25, 8'h28, 8'h29, 8'h2a, 8'h2c, 8'h30};
    int         failures = 0, samples_checked = 0, cycles = 0, seed;
    apccc_top #(.MISS_STEP_CYC(200), .FRAME_MIN(100), .FRAME_MAX(2000)) dut (
        .clk_sys(clk_sys), .rst_b(rst_b), .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mclk_pin(mclk_pin), .bclk_pin(bclk_pin),
        .lrclk_pin(lrclk_pin), .pll_locked(pll_locked), .manual_dac_div(manual_dac_div),
        .divider_auto(divider_auto), .dac_div(dac_div), .audio_format_select(fmt), .sample_bits(bits),
        .sample_offset(ofs), .left_path_select(lp), .right_path_select(rp), .clock_error(ce),
        .dac_powerdown(pd));
    apccc_source src (.clk_sys(clk_sys), .run(run), .mclk_on(mclk_on), .half_bclks(half),
        .mclk_pin(mclk_pin), .bclk_pin(bclk_pin), .lrclk_pin(lrclk_pin));
    initial forever #4 clk_sys = ~clk_sys;
    task automatic report_and_stop();
        if (failures == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            failures++;
            report_and_stop();
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        if (mdl.exists(a)) mdl[a] = v;
        tick(1);
        reg_wr <= 1'b0;
        tick(3);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        tick(1);
        reg_rd <= 1'b0;
        tick(1);
        v = reg_rdata;
    endtask
    function automatic logic [7:0] model_rd(input logic [7:0] a);
        case (a)
            ADDR_CLK_CHECK: return mdl[a] & 8'h7f;
            ADDR_FMT_LEN:   return mdl[a] & 8'h33;
            ADDR_DATA_OFS:  return mdl[a];
            ADDR_PATH_SEL:  return mdl[a] & 8'h33;
            ADDR_MISS_PER:  return mdl[a] & 8'h07;
            default:        return 8'h00;
        endcase
    endfunction
    task automatic rchk(input logic [7:0] a);
        logic [7:0] v;
        rd(a, v);
        chk(v, model_rd(a));
    endtask
    task automatic ign_case(input logic [7:0] ign, input int n, input logic exp);
        wr(ADDR_CLK_CHECK, ign);
        tick(n);
        chk({7'h0, ce}, {7'h0, exp});
    endtask
    initial begin
        seed = 32'h3103;
        mdl[ADDR_CLK_CHECK] = 8'h00;
        mdl[ADDR_FMT_LEN] = 8'h02;
        mdl[ADDR_DATA_OFS] = 8'h00;
        mdl[ADDR_PATH_SEL] = 8'h11;
        mdl[ADDR_MISS_PER] = 8'h00;
        tick(4);
        rst_b <= 1'b1;
        tick(1);
        chk({2'h0, bits}, 8'h18);
        chk({7'h0, divider_auto}, 8'h01);
        foreach (addrs[i]) rchk(addrs[i]);
        tick(1400);
        chk({7'h0, ce}, 8'h00);
        chk({1'h0, dac_div}, 8'h00);
        for (int i = 0; i < 16; i++) begin
            d = 8'($random(seed));
            d[5:4] = i[3:2];
            d[1:0] = i[1:0];
            wr(ADDR_FMT_LEN, d);
            chk({6'h0, fmt}, {6'h0, d[5:4]});
            chk({2'h0, bits}, (d[1:0] == 2'h3) ? 8'h20 : 8'h10 + 8'h04 * d[1:0]);
            rchk(ADDR_FMT_LEN);
        end
        for (int i = 0; i < 4; i++) begin
            d = (i == 0) ? 8'h00 : (i == 3) ? 8'hff : 8'($random(seed));
            wr(ADDR_DATA_OFS, d);
            chk(ofs, d);
            rchk(ADDR_DATA_OFS);
        end
        for (int i = 0; i < 9; i++) begin
            d = 8'($random(seed));
            d[5:4] = 2'(i / 3);
            d[1:0] = 2'(i % 3);
            wr(ADDR_PATH_SEL, d);
            chk({4'h0, lp, rp}, {4'h0, d[5:4], d[1:0]});
            rchk(ADDR_PATH_SEL);
        end
        manual_dac_div <= 7'($random(seed));
        wr(ADDR_CLK_CHECK, 8'h02);
        chk({7'h0, divider_auto}, 8'h00);
        chk({1'h0, dac_div}, {1'h0, manual_dac_div});
        rchk(ADDR_CLK_CHECK);
        ign_case(8'h00, 4, 1'b0);
        chk({1'h0, dac_div}, 8'h00);
        pll_locked <= 1'b0;
        tick(8);
        chk({7'h0, ce}, 8'h01);
        chk({6'h0, lp}, 8'h00);
        ign_case(8'h01, 4, 1'b0);
        rd(ADDR_STATUS, d);
        chk({7'h0, d[4]}, 8'h00);
        pll_locked <= 1'b1;
        ign_case(8'h00, 8, 1'b0);
        rd(ADDR_STATUS, d);
        chk({7'h0, d[4]}, 8'h01);
        half <= 8'd8;
        tick(700);
        chk({7'h0, ce}, 8'h01);
        ign_case(8'h20, 400, 1'b1);
        ign_case(8'h30, 400, 1'b0);
        half <= 8'd160;
        tick(6000);
        chk({7'h0, ce}, 8'h01);
        ign_case(8'h70, 4, 1'b0);
        half <= 8'd32;
        ign_case(8'h00, 3000, 1'b0);
        wr(ADDR_CLK_CHECK, 8'h10);
        mclk_on <= 1'b0;
        tick(200);
        chk({7'h0, ce}, 8'h01);
        ign_case(8'h18, 4, 1'b0);
        mclk_on <= 1'b1;
        ign_case(8'h00, 1600, 1'b0);
        wr(ADDR_MISS_PER, 8'h01);
        rchk(ADDR_MISS_PER);
        run <= 1'b0;
        tick(350);
        chk({7'h0, pd}, 8'h00);
        tick(70);
        chk({7'h0, pd}, 8'h01);
        wr(ADDR_CLK_CHECK, 8'h04);
        chk({7'h0, pd}, 8'h00);
        d = mdl[ADDR_DATA_OFS];
        clk_en <= 1'b0;
        wr(ADDR_DATA_OFS, 8'h5a);
        mdl[ADDR_DATA_OFS] = d;
        chk(ofs, d);
        clk_en <= 1'b1;
        rchk(ADDR_DATA_OFS);
        report_and_stop();
    end
endmodule // audio_port_clock_check_config_bench
`default_nettype wire
